// File: common/hrb_consts.svh
/*
 * Constants for the health attribute record builder: identifiers, fixed
 * record bytes, counter widths and record geometry.
 * Assumes it is included by bare name from the package and design files.
 */
`ifndef HRB_CONSTS_SVH
`define HRB_CONSTS_SVH

`define HRB_NUM_CNT        6
`define HRB_REC_BYTES      12
`define HRB_CNT_W          48
`define HRB_SECTOR_RES_W   16

`define HRB_ID_ECC_TOTAL   8'hcb
`define HRB_ID_ECC_CORR    8'hcc
`define HRB_ID_LINK_CRC    8'hc7
`define HRB_ID_READ_CMD    8'he8
`define HRB_ID_POWER_ON    8'h0c
`define HRB_ID_WRITE_VOL   8'hf1

`define HRB_FLAGS_ADVISORY 16'h0002
`define HRB_FIXED_VALUE    8'h64

`define HRB_MAX_4B         48'h0000_ffff_ffff
`define HRB_MAX_6B         48'hffff_ffff_ffff

`define HRB_BYTE_ID        0
`define HRB_BYTE_FLAG_LO   1
`define HRB_BYTE_FLAG_HI   2
`define HRB_BYTE_CUR       3
`define HRB_BYTE_WORST     4
`define HRB_BYTE_RAW       5
`define HRB_BYTE_RSVD      11

`endif

// File: common/hrb_pkg.sv
/*
 * Types for the health attribute record builder.
 * Assumes hrb_consts.svh is on the include path.
 */
`include "hrb_consts.svh"

package hrb_pkg;

    typedef enum logic [2:0] {
        HRB_ECC_TOTAL,
        HRB_ECC_CORR,
        HRB_LINK_CRC,
        HRB_READ_CMD,
        HRB_POWER_ON,
        HRB_WRITE_VOL
    } hrb_sel_t;

    typedef enum logic {
        HRB_PH_WAIT,
        HRB_PH_RUN
    } hrb_phase_t;

    typedef logic [`HRB_REC_BYTES-1:0][7:0] hrb_rec_t;
    typedef logic [`HRB_NUM_CNT-1:0][`HRB_CNT_W-1:0] hrb_cnt_arr_t;

    typedef struct packed {
        logic ecc_err;
        logic ecc_corrected;
        logic crc_err;
        logic read_cmd;
        logic sector_wr;
    } hrb_evt_t;

    typedef struct packed {
        hrb_cnt_arr_t                 cnt;
        logic [`HRB_SECTOR_RES_W-1:0] sector_res;
    } hrb_nv_t;

    typedef struct packed {
        hrb_phase_t phase;
        hrb_nv_t    nv;
        hrb_rec_t   rec;
        hrb_sel_t   rec_sel;
        logic       rec_valid;
    } hrb_state_t;

endpackage

// File: design/hrb_record_fmt.sv
/*
 * Lays out one 12-byte health attribute record from a selected counter.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/1ps
`include "hrb_consts.svh"

module hrb_record_fmt (
    input  wire hrb_pkg::hrb_sel_t            sel,
    input  wire logic [`HRB_CNT_W-1:0]        cnt,
    output hrb_pkg::hrb_rec_t                 rec
);
    import hrb_pkg::*;

    // sized copy so each flag byte is a plain part-select
    localparam logic [15:0] FLAGS = `HRB_FLAGS_ADVISORY;

    logic [7:0] id;
    logic       six_byte;

    always_comb begin
        six_byte = 1'b0;
        case (sel)
            // (RULE3) total ecc id
            HRB_ECC_TOTAL: id = `HRB_ID_ECC_TOTAL;
            // (RULE4) corrected ecc id
            HRB_ECC_CORR:  id = `HRB_ID_ECC_CORR;
            // (RULE5) link crc id
            HRB_LINK_CRC:  id = `HRB_ID_LINK_CRC;
            // (RULE6) read count id, wide field
            HRB_READ_CMD: begin
                id       = `HRB_ID_READ_CMD;
                six_byte = 1'b1;
            end
            // (RULE7) power-up id
            HRB_POWER_ON:  id = `HRB_ID_POWER_ON;
            // (RULE8) write volume id, wide field
            HRB_WRITE_VOL: begin
                id       = `HRB_ID_WRITE_VOL;
                six_byte = 1'b1;
            end
            default:       id = 8'h00;
        endcase
    end

    always_comb begin
        rec = '0;
        rec[`HRB_BYTE_ID] = id;
        // (RULE2) advisory flag word
        rec[`HRB_BYTE_FLAG_LO] = FLAGS[7:0];
        rec[`HRB_BYTE_FLAG_HI] = FLAGS[15:8];
        // (RULE1) fixed current and worst
        rec[`HRB_BYTE_CUR]   = `HRB_FIXED_VALUE;
        rec[`HRB_BYTE_WORST] = `HRB_FIXED_VALUE;
        // (RULE10) raw counter lsb first
        for (int k = 0; k < 6; k++) begin
            // (RULE11) upper raw bytes zero
            if (k < 4 || six_byte) begin
                rec[`HRB_BYTE_RAW + k] = cnt[8*k +: 8];
            end
        end
        // (RULE11) reserved byte zero
        rec[`HRB_BYTE_RSVD] = 8'h00;
    end

endmodule

// File: design/hrb_builder.sv
/*
 * Health attribute record builder: keeps six advisory event counters and
 * returns a formatted 12-byte record on request.
 * Assumes event inputs are single-cycle pulses synchronous to clk_sys and
 * that an outside store saves nv_img_out and hands it back via nv_load
 * after each power-up.
 */
`timescale 1ns/1ps
`include "hrb_consts.svh"

// Summary of operation
// (RULE1) current and worst value fixed 64h
// (RULE2) flag word 0002h in bytes 1-2
// (RULE3) CBh record counts every ecc error
// (RULE4) CCh record counts corrected ecc errors
// (RULE5) C7h record counts link crc errors
// (RULE6) E8h six-byte count of flash reads
// (RULE7) 0Ch record counts power-on cycles
// (RULE8) F1h six-byte count of 65536-sector units
// (RULE9) no record joins threshold evaluation
// (RULE10) multi-byte fields least significant first
// (RULE11) byte 11 and unused raw bytes zero
// (RULE12) counters saturate and persist across power
module hrb_builder (
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire hrb_pkg::hrb_evt_t     evt,
    input  wire logic                  nv_load,
    input  wire hrb_pkg::hrb_nv_t      nv_img_in,
    output hrb_pkg::hrb_nv_t           nv_img_out,
    output logic                       cnt_ready,
    input  wire logic                  rec_req,
    input  wire hrb_pkg::hrb_sel_t     rec_sel_in,
    output logic                       rec_valid,
    output hrb_pkg::hrb_sel_t          rec_sel,
    output hrb_pkg::hrb_rec_t          rec_data,
    output logic                       rec_thresh
);
    import hrb_pkg::*;

    hrb_state_t            st;
    hrb_state_t            next_st;
    logic [`HRB_NUM_CNT-1:0] inc;
    logic [`HRB_NUM_CNT-1:0] at_max;
    hrb_cnt_arr_t          cnt_bumped;
    hrb_cnt_arr_t          img_pwr;
    hrb_rec_t              fmt_rec;
    logic                  unit_done;

    // write path: one unit per full 65536-sector wrap of the residue
    assign unit_done = evt.sector_wr && (&st.nv.sector_res);

    always_comb begin
        inc = '0;
        // (RULE3) every ecc error
        inc[HRB_ECC_TOTAL] = evt.ecc_err;
        // (RULE4) only corrected errors
        inc[HRB_ECC_CORR]  = evt.ecc_err && evt.ecc_corrected;
        // (RULE5) link crc errors
        inc[HRB_LINK_CRC]  = evt.crc_err;
        // (RULE6) flash read commands
        inc[HRB_READ_CMD]  = evt.read_cmd;
        inc[HRB_POWER_ON]  = 1'b0;
        // (RULE8) one per 32MB written
        inc[HRB_WRITE_VOL] = unit_done;
    end

    genvar g;
    generate
        for (g = 0; g < `HRB_NUM_CNT; g++) begin : g_cnt
            localparam logic [`HRB_CNT_W-1:0] MAXV =
                (g == HRB_READ_CMD || g == HRB_WRITE_VOL) ?
                `HRB_MAX_6B : `HRB_MAX_4B;
            // (RULE12) saturate, never wrap
            assign at_max[g]     = st.nv.cnt[g] >= MAXV;
            assign cnt_bumped[g] = (inc[g] && !at_max[g]) ?
                                   st.nv.cnt[g] + 48'h1 : st.nv.cnt[g];
            // (RULE12) restored image, power count saturating
            if (g == HRB_POWER_ON) begin : g_pwr
                assign img_pwr[g] = (nv_img_in.cnt[g] >= MAXV) ?
                                    MAXV : nv_img_in.cnt[g] + 48'h1;
            end else begin : g_other
                assign img_pwr[g] = (nv_img_in.cnt[g] > MAXV) ?
                                    MAXV : nv_img_in.cnt[g];
            end
        end
    endgenerate

    hrb_record_fmt u_fmt (
        .sel (rec_sel_in),
        .cnt (st.nv.cnt[rec_sel_in]),
        .rec (fmt_rec)
    );

    always_comb begin
        next_st           = st;
        next_st.rec_valid = 1'b0;
        case (st.phase)
            HRB_PH_WAIT: begin
                // events before the image is back would be overwritten
                if (nv_load) begin
                    // (RULE7) one more power-on cycle
                    next_st.nv.cnt        = img_pwr;
                    next_st.nv.sector_res = nv_img_in.sector_res;
                    next_st.phase         = HRB_PH_RUN;
                end
            end
            HRB_PH_RUN: begin
                next_st.nv.cnt = cnt_bumped;
                if (evt.sector_wr) begin
                    // (RULE8) residue wraps into a unit
                    next_st.nv.sector_res = st.nv.sector_res + 16'h1;
                end
            end
            default: next_st.phase = HRB_PH_WAIT;
        endcase
        if (rec_req) begin
            // record shows counts as they stood before this cycle's events
            next_st.rec       = fmt_rec;
            next_st.rec_sel   = rec_sel_in;
            next_st.rec_valid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st         <= '0;
            st.phase   <= HRB_PH_WAIT;
            st.rec_sel <= HRB_ECC_TOTAL;
        end else begin
            st <= next_st;
        end
    end

    assign nv_img_out = st.nv;
    assign cnt_ready  = (st.phase == HRB_PH_RUN);
    assign rec_valid  = st.rec_valid;
    assign rec_sel    = st.rec_sel;
    assign rec_data   = st.rec;
    // (RULE9) advisory records never trip threshold
    assign rec_thresh = 1'b0;

    AST_FIXED_VALUE: assert property (  // (RULE1)
        @(posedge clk_sys) disable iff (sys_rst)
        rec_req |=> rec_valid && rec_data[3] == 8'h64
                    && rec_data[4] == 8'h64)
        else $error("fixed value bytes not 64h");

    AST_FLAG_WORD: assert property (  // (RULE2)
        @(posedge clk_sys) disable iff (sys_rst)
        rec_valid |-> {rec_data[2], rec_data[1]} == 16'h0002)
        else $error("flag word not 0002h");

    AST_ECC_TOTAL: assert property (  // (RULE3)
        @(posedge clk_sys) disable iff (sys_rst)
        cnt_ready && evt.ecc_err && !at_max[0]
        |=> st.nv.cnt[0] == $past(st.nv.cnt[0]) + 48'h1)
        else $error("total ecc count missed an error");

    AST_ECC_CORR: assert property (  // (RULE4)
        @(posedge clk_sys) disable iff (sys_rst)
        cnt_ready && !(evt.ecc_err && evt.ecc_corrected)
        |=> $stable(st.nv.cnt[1]))
        else $error("corrected count moved without corrected error");

    AST_CRC_ID: assert property (  // (RULE5)
        @(posedge clk_sys) disable iff (sys_rst)
        rec_req && rec_sel_in == HRB_LINK_CRC
        |=> rec_data[0] == 8'hc7 && rec_sel == HRB_LINK_CRC)
        else $error("link crc record id wrong");

    AST_READ_CNT: assert property (  // (RULE6)
        @(posedge clk_sys) disable iff (sys_rst)
        cnt_ready && evt.read_cmd && !at_max[3]
        |=> st.nv.cnt[3] == $past(st.nv.cnt[3]) + 48'h1)
        else $error("read count missed a read command");

    AST_READ_REC: assert property (  // (RULE6)
        @(posedge clk_sys) disable iff (sys_rst)
        rec_req && rec_sel_in == HRB_READ_CMD
        |=> rec_data[0] == 8'he8
            && {rec_data[10], rec_data[9], rec_data[8], rec_data[7],
                rec_data[6], rec_data[5]} == $past(st.nv.cnt[3]))
        else $error("read count record wrong");

    AST_POWER_UP: assert property (  // (RULE7)
        @(posedge clk_sys) disable iff (sys_rst)
        !cnt_ready && nv_load && nv_img_in.cnt[4] < 48'h0000_ffff_ffff
        |=> cnt_ready && st.nv.cnt[4] == $past(nv_img_in.cnt[4]) + 48'h1)
        else $error("power-on count not advanced on restore");

    AST_WRITE_UNIT: assert property (  // (RULE8)
        @(posedge clk_sys) disable iff (sys_rst)
        cnt_ready && evt.sector_wr && st.nv.sector_res == 16'hffff
        && !at_max[5]
        |=> st.nv.sector_res == 16'h0000
            && st.nv.cnt[5] == $past(st.nv.cnt[5]) + 48'h1)
        else $error("write volume unit not counted");

    AST_NO_THRESH: assert property (  // (RULE9)
        @(posedge clk_sys) disable iff (sys_rst)
        rec_valid |-> !rec_thresh)
        else $error("advisory record flagged threshold");

    AST_LSB_FIRST: assert property (  // (RULE10)
        @(posedge clk_sys) disable iff (sys_rst)
        rec_req && rec_sel_in == HRB_ECC_TOTAL
        |=> {rec_data[8], rec_data[7], rec_data[6], rec_data[5]}
            == $past(st.nv.cnt[0][31:0]))
        else $error("raw field byte order wrong");

    AST_ZERO_BYTES: assert property (  // (RULE11)
        @(posedge clk_sys) disable iff (sys_rst)
        rec_valid && rec_sel != HRB_READ_CMD && rec_sel != HRB_WRITE_VOL
        |-> rec_data[9] == 8'h00 && rec_data[10] == 8'h00
            && rec_data[11] == 8'h00)
        else $error("unused record bytes not zero");

    AST_SATURATE: assert property (  // (RULE12)
        @(posedge clk_sys) disable iff (sys_rst)
        cnt_ready && at_max[0]
        |=> st.nv.cnt[0] == 48'h0000_ffff_ffff)
        else $error("total ecc counter left its maximum");

endmodule

// File: test/hrb_host.sv
/*
 * Host model: asks the builder for one health record at a time.
 * Assumes the record comes back exactly one cycle after the request edge.
 */
`timescale 1ns/1ps

module hrb_host (
    input  wire logic              clk_sys,
    input  wire logic              rec_valid,
    input  wire hrb_pkg::hrb_rec_t rec_data,
    output logic                   rec_req,
    output hrb_pkg::hrb_sel_t      rec_sel_in
);
    import hrb_pkg::*;

    initial begin
        rec_req    = 1'b0;
        rec_sel_in = HRB_ECC_TOTAL;
    end

    // selector is scrambled once the request is gone
    task automatic read_rec(input hrb_sel_t s, output hrb_rec_t r,
                            output logic ok);
        @(posedge clk_sys);
        rec_req    <= 1'b1;
        rec_sel_in <= s;
        @(posedge clk_sys);
        rec_req    <= 1'b0;
        rec_sel_in <= hrb_sel_t'(~s);
        #1;
        ok = rec_valid;
        r  = rec_data;
    endtask
endmodule

// File: test/hrb_builder_test.sv
/*
 * Self-checking bench for the health attribute record builder.
 * Assumes the counter image index equals the record selector.
 */
`timescale 1ns/1ps

module hrb_builder_test;
    import hrb_pkg::*;

    logic        clk_sys;
    logic        sys_rst;
    logic        nv_load;
    logic        cnt_ready;
    logic        rec_req;
    logic        rec_valid;
    logic        rec_thresh;
    hrb_evt_t    evt;
    hrb_nv_t     nv_img_in;
    hrb_nv_t     nv_img_out;
    hrb_sel_t    rec_sel_in;
    hrb_sel_t    rec_sel;
    hrb_rec_t    rec_data;
    logic [47:0] exp_cnt [6];
    int          n_errors;
    int          check_count;

    hrb_builder i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .evt(evt),
        .nv_load(nv_load), .nv_img_in(nv_img_in), .nv_img_out(nv_img_out),
        .cnt_ready(cnt_ready), .rec_req(rec_req), .rec_sel_in(rec_sel_in),
        .rec_valid(rec_valid), .rec_sel(rec_sel), .rec_data(rec_data),
        .rec_thresh(rec_thresh));

    hrb_host i_host (.clk_sys(clk_sys), .rec_valid(rec_valid),
        .rec_data(rec_data), .rec_req(rec_req), .rec_sel_in(rec_sel_in));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp_rec(string name, hrb_rec_t e, hrb_rec_t g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic cmp_flag(string name, logic e, logic g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", name, e, g);
        end
    endtask

    function automatic hrb_rec_t exp_rec(hrb_sel_t s, logic [47:0] c);
        hrb_rec_t   r;
        logic [7:0] ids [6];
        ids = '{8'hcb, 8'hcc, 8'hc7, 8'he8, 8'h0c, 8'hf1};
        r = '0;
        r[0] = ids[s];
        r[1] = 8'h02;
        r[3] = 8'h64;
        r[4] = 8'h64;
        for (int k = 0; k < 6; k++) begin
            if (k < 4 || s == HRB_READ_CMD || s == HRB_WRITE_VOL)
                r[5+k] = c[8*k +: 8];
        end
        return r;
    endfunction

    // every record read back and laid out against the model counts
    task automatic check_all();
        hrb_rec_t r;
        logic     ok;
        for (int s = 0; s < 6; s++) begin
            i_host.read_rec(hrb_sel_t'(s), r, ok);
            cmp_flag("rec_valid", 1'b1, ok);
            cmp_rec("rec_data", exp_rec(hrb_sel_t'(s), exp_cnt[s]),
                    r);
            cmp_flag("rec_sel", 1'b1, rec_sel === hrb_sel_t'(s));
            cmp_flag("rec_thresh", 1'b0, rec_thresh);
        end
    endtask

    // holds the event bits for n back-to-back cycles
    task automatic pulse_n(hrb_evt_t e, int n);
        @(posedge clk_sys);
        evt <= e;
        repeat (n) @(posedge clk_sys);
        evt <= '0;
    endtask

    task automatic t_restore();
        hrb_nv_t img;
        img = '0;
        img.cnt[0] = 48'h0000_ffff_fffe;
        img.cnt[4] = 48'h5;
        img.cnt[5] = 48'ha;
        img.sector_res = 16'hfffe;
        pulse_n(5'b00100, 2);
        @(posedge clk_sys);
        nv_load   <= 1'b1;
        nv_img_in <= img;
        @(posedge clk_sys);
        nv_load   <= 1'b0;
        nv_img_in <= ~img;
        #1;
        cmp_flag("cnt_ready", 1'b1, cnt_ready);
        cmp_flag("nv_img_out", 1'b1, nv_img_out.cnt[4] === 48'h6);
        foreach (exp_cnt[i]) exp_cnt[i] = img.cnt[i];
        exp_cnt[4] = 48'h6;
        check_all();
    endtask

    task automatic t_events();
        pulse_n(5'b10000, 3);
        pulse_n(5'b11000, 2);
        // corrected flag without an error must not count
        pulse_n(5'b01000, 1);
        pulse_n(5'b00100, 1);
        pulse_n(5'b00010, 4);
        exp_cnt[0] = 48'h0000_ffff_ffff;
        exp_cnt[1] = 48'h2;
        exp_cnt[2] = 48'h1;
        exp_cnt[3] = 48'h4;
        check_all();
    endtask

    // residue starts at fffe: one write short, then the 65536th sector
    task automatic t_write();
        pulse_n(5'b00001, 1);
        #1;
        cmp_flag("sector_res", 1'b1,
                 nv_img_out.sector_res === 16'hffff);
        check_all();
        pulse_n(5'b00001, 1);
        #1;
        cmp_flag("sector_res", 1'b1,
                 nv_img_out.sector_res === 16'h0000);
        exp_cnt[5] = 48'hb;
        check_all();
    endtask

    initial begin
        #(5000 * 50);
        n_errors++;
        end_of_test();
    end

    initial begin
        n_errors    = 0;
        check_count = 0;
        sys_rst     = 1'b1;
        evt         = '0;
        nv_load     = 1'b0;
        nv_img_in   = '0;
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        cmp_flag("cnt_ready", 1'b0, cnt_ready);
        cmp_flag("nv_img_out", 1'b1, nv_img_out === '0);
        t_restore();
        t_events();
        t_write();
        end_of_test();
    end
endmodule
